// ---- rtl/lcd_instr_decoder.sv ----
// instruction decoder of a character display controller, APB slave
// assumes an APB master on clock; option pins static
//
// Overview of operation
// - one-line layout accepts text addresses 00H to 4FH only.
// - two-line layout uses rows 00H-27H and 40H-67H.
// - instruction read returns busy on bit 7, pointer on bits 6-0.
// - pointer steps by one after each text or glyph data access.
// - data write stores the byte at the pointer in the chosen RAM.
// - last address-set picks the RAM for data reads and writes.
// - bias-select high gives 1/4 bias, low gives 1/5 bias.
// - bias-select ignored when both follower options are high.
// - oscillator trim acts only with the oscillator-adjust pin high.
// - extended icon address loads four bits, range 00H to 0FH.
// - icon-enable bit turns the icon display on or off.
// - booster bit acts only with both follower options low.
// - six-bit contrast from two instructions, internal follower only.
// - follower-enable settable only with both follower options low.
// - follower gain accepted only with internal follower selected.
// - table-select high picks extended table, low the normal one.
// - step-direction high increments the pointer, low decrements.
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "lcd_decoder_consts.svh"
`default_nettype none
module lcd_instr_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // option pins
  input wire logic follower_option_a,
  input wire logic follower_option_b,
  input wire logic osc_adjust_pin,
  // settings to the analog and timing sections
  output lcd_decoder_pkg::settings_t settings,
  output logic [2:0] osc_trim_active
);
  lcd_decoder_pkg::settings_t set_ff;
  lcd_decoder_pkg::ram_sel_t ram_sel_ff;
  lcd_decoder_pkg::port_cmd_t cmd;
  logic [6:0] ram_pointer_ff;
  logic [7:0] rdata_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [2:0] osc_ff;
  logic internal_busy_indicator;
  logic access;
  logic port_hit;
  logic instr_wr;
  logic data_wr;
  logic data_rd;
  logic status_rd;
  logic internal_follower;
  logic ext_bias;
  logic [6:0] nxt_pointer;
  logic addr_ok;
  logic [7:0] mem_rdata;
  logic [7:0] db;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  // one APB access phase is one enable strobe
  assign access = psel && penable && !pready_ff;
  assign port_hit = access && pwrite && (paddr == `REG_PORT);
  assign cmd = lcd_decoder_pkg::port_cmd_t'(pwdata[9:0]);
  assign db = cmd.db;
  // byte, select and direction taken together on one strobe
  assign instr_wr = port_hit && !cmd.register_select && !cmd.read_not_write;
  assign data_wr = port_hit && cmd.register_select && !cmd.read_not_write;
  assign data_rd = port_hit && cmd.register_select && cmd.read_not_write;
  assign status_rd = access && !pwrite && (paddr == `REG_STATUS);
  assign internal_follower = !follower_option_a && !follower_option_b;
  assign ext_bias = follower_option_a && follower_option_b;

  // ---------------------------------------------------------------
  // busy timer and memories
  // ---------------------------------------------------------------
  lcd_busy_timer u_busy (
    .clock(clock),
    .arst_n(arst_n),
    .start(instr_wr || data_wr || data_rd),
    .busy(internal_busy_indicator)
  );

  lcd_ram_store u_ram (
    .clock(clock),
    .we(data_wr),
    .sel(ram_sel_ff),
    .addr(ram_pointer_ff),
    .wdata(db),
    .rdata(mem_rdata)
  );

  // ---------------------------------------------------------------
  // pointer step with wrap inside the selected RAM
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pointer = ram_pointer_ff;
    if (set_ff.step_up) begin
      nxt_pointer = ram_pointer_ff + 7'h01;
    end else begin
      nxt_pointer = ram_pointer_ff - 7'h01;
    end
    case (ram_sel_ff)
      lcd_decoder_pkg::RAM_TEXT: begin
        if (set_ff.two_line) begin
          if (set_ff.step_up && ram_pointer_ff == `TEXT_ROW0_MAX) begin
            nxt_pointer = `TEXT_ROW1_MIN;
          end else if (set_ff.step_up && ram_pointer_ff == `TEXT_ROW1_MAX) begin
            nxt_pointer = 7'h00;
          end else if (!set_ff.step_up && ram_pointer_ff == `TEXT_ROW1_MIN) begin
            nxt_pointer = `TEXT_ROW0_MAX;
          end else if (!set_ff.step_up && ram_pointer_ff == 7'h00) begin
            nxt_pointer = `TEXT_ROW1_MAX;
          end
        end else begin
          if (set_ff.step_up && ram_pointer_ff == `TEXT_ONE_LINE_MAX) begin
            nxt_pointer = 7'h00;
          end else if (!set_ff.step_up && ram_pointer_ff == 7'h00) begin
            nxt_pointer = `TEXT_ONE_LINE_MAX;
          end
        end
      end
      lcd_decoder_pkg::RAM_GLYPH: nxt_pointer = nxt_pointer & `GLYPH_MAX;
      lcd_decoder_pkg::RAM_ICON: nxt_pointer = nxt_pointer & `ICON_MAX;
      default: nxt_pointer = ram_pointer_ff;
    endcase
  end

  // text address legal for the current layout
  always_comb begin
    if (set_ff.two_line) begin
      addr_ok = (db[6:0] <= `TEXT_ROW0_MAX) ||
                (db[6:0] >= `TEXT_ROW1_MIN && db[6:0] <= `TEXT_ROW1_MAX);
    end else begin
      addr_ok = (db[6:0] <= `TEXT_ONE_LINE_MAX);
    end
  end

  // ---------------------------------------------------------------
  // pointer and RAM selection
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ram_pointer_ff <= 7'h00;
      ram_sel_ff <= lcd_decoder_pkg::RAM_TEXT;
    end else if (instr_wr && db[7]) begin
      if (addr_ok) begin
        ram_pointer_ff <= db[6:0];
        ram_sel_ff <= lcd_decoder_pkg::RAM_TEXT;
      end
    end else if (instr_wr && db[7:6] == 2'b01 && !set_ff.table_select) begin
      ram_pointer_ff <= {1'b0, db[5:0]};
      ram_sel_ff <= lcd_decoder_pkg::RAM_GLYPH;
    end else if (instr_wr && db[7:4] == 4'h4 && set_ff.table_select) begin
      ram_pointer_ff <= {3'h0, db[3:0]};
      ram_sel_ff <= lcd_decoder_pkg::RAM_ICON;
    end else if (data_wr || data_rd) begin
      ram_pointer_ff <= nxt_pointer;
    end
  end

  // ---------------------------------------------------------------
  // mode and analog settings
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      set_ff <= '0;
      set_ff.step_up <= 1'b1;
      set_ff.osc_trim <= `RST_OSC_TRIM;
      set_ff.follower_gain <= `RST_GAIN;
      set_ff.contrast_code <= `RST_CONTRAST;
    end else if (instr_wr) begin
      if (db[7:2] == 6'b000001) begin
        set_ff.step_up <= db[1];
      end else if (db[7:5] == 3'b001) begin
        set_ff.two_line <= db[3];
        set_ff.table_select <= db[0];
      end else if (set_ff.table_select) begin
        case (db[7:4])
          4'h1: begin
            if (!ext_bias) begin
              set_ff.bias_select <= db[3];
            end
            set_ff.osc_trim <= db[2:0];
          end
          4'h5: begin
            set_ff.icon_on <= db[3];
            if (internal_follower) begin
              set_ff.booster_on <= db[2];
              set_ff.contrast_code[5:4] <= db[1:0];
            end
          end
          4'h6: begin
            if (internal_follower) begin
              set_ff.follower_on <= db[3];
              set_ff.follower_gain <= db[2:0];
            end
          end
          4'h7: begin
            if (internal_follower) begin
              set_ff.contrast_code[3:0] <= db[3:0];
            end
          end
          default: set_ff <= set_ff;
        endcase
      end
    end
  end

  // trim reaches the oscillator only with the adjust pin high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_ff <= `RST_OSC_TRIM;
    end else if (osc_adjust_pin) begin
      osc_ff <= set_ff.osc_trim;
    end
  end

  // ---------------------------------------------------------------
  // read data latch and APB answer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (data_rd) begin
      rdata_ff <= mem_rdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      if (access && !pwrite) begin
        case (paddr)
          `REG_STATUS: prdata_ff <= {24'h00_0000, internal_busy_indicator,
                                     ram_pointer_ff};
          `REG_CONFIG: prdata_ff <= {13'h0000, set_ff};
          `REG_POWER: prdata_ff <= {26'h000_0000, ext_bias, internal_follower,
                                    osc_adjust_pin, osc_ff};
          `REG_RDATA: prdata_ff <= {24'h00_0000, rdata_ff};
          `REG_PORT: prdata_ff <= 32'h0000_0000;
          default: pslverr_ff <= 1'b1;
        endcase
      end else if (access && paddr != `REG_PORT) begin
        pslverr_ff <= 1'b1;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign settings = set_ff;
  assign osc_trim_active = osc_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_ext_bias_hold;
    @(posedge clock) disable iff (!arst_n)
    ext_bias |=> $stable(set_ff.bias_select);
  endproperty
  a_ext_bias_hold: assert property (p_ext_bias_hold) else $error("bias changed");

  property p_follower_lock;
    @(posedge clock) disable iff (!arst_n)
    !internal_follower |=> $stable(set_ff.follower_gain) && $stable(set_ff.contrast_code)
      && $stable(set_ff.booster_on) && $stable(set_ff.follower_on);
  endproperty
  a_follower_lock: assert property (p_follower_lock) else $error("follower set");

  property p_step_up;
    @(posedge clock) disable iff (!arst_n)
    (data_wr && set_ff.step_up && ram_sel_ff == lcd_decoder_pkg::RAM_GLYPH
      && ram_pointer_ff != `GLYPH_MAX) |=> ram_pointer_ff == $past(ram_pointer_ff) + 7'h01;
  endproperty
  a_step_up: assert property (p_step_up) else $error("no increment");

  property p_one_line_range;
    @(posedge clock) disable iff (!arst_n)
    (!set_ff.two_line && ram_sel_ff == lcd_decoder_pkg::RAM_TEXT)
      |-> ram_pointer_ff <= `TEXT_ONE_LINE_MAX;
  endproperty
  a_one_line_range: assert property (p_one_line_range) else $error("text range");

  property p_icon_range;
    @(posedge clock) disable iff (!arst_n)
    ram_sel_ff == lcd_decoder_pkg::RAM_ICON |-> ram_pointer_ff <= `ICON_MAX;
  endproperty
  a_icon_range: assert property (p_icon_range) else $error("icon range");

  property p_busy_after;
    @(posedge clock) disable iff (!arst_n)
    instr_wr |=> internal_busy_indicator [*8];
  endproperty
  a_busy_after: assert property (p_busy_after) else $error("busy short");

  // status word carries busy and pointer of the access cycle
  property p_status_read;
    @(posedge clock) disable iff (!arst_n)
    status_rd |=> prdata_ff == {24'h00_0000, $past(internal_busy_indicator),
                                $past(ram_pointer_ff)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word");

  property p_table_gate;
    @(posedge clock) disable iff (!arst_n)
    (instr_wr && !set_ff.table_select && db[7:4] == 4'h5) |=> $stable(set_ff.icon_on);
  endproperty
  a_table_gate: assert property (p_table_gate) else $error("table gate");

  property p_osc_gate;
    @(posedge clock) disable iff (!arst_n)
    !osc_adjust_pin |=> $stable(osc_ff);
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("trim moved");
endmodule
`default_nettype wire

// ---- rtl/lcd_decoder_consts.svh ----
// constants for the character display instruction decoder
// assumes inclusion by bare name from the design files
`ifndef LCD_DECODER_CONSTS_SVH
`define LCD_DECODER_CONSTS_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_PORT 12'h000
`define REG_STATUS 12'h004
`define REG_CONFIG 12'h008
`define REG_POWER 12'h00C
`define REG_RDATA 12'h010
// ---------------------------------------------------------------
// port command fields and address limits
// ---------------------------------------------------------------
`define PORT_RS_BIT 9
`define PORT_RW_BIT 8
`define TEXT_ONE_LINE_MAX 7'h4F
`define TEXT_ROW0_MAX 7'h27
`define TEXT_ROW1_MIN 7'h40
`define TEXT_ROW1_MAX 7'h67
`define GLYPH_MAX 7'h3F
`define ICON_MAX 7'h0F
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define EXEC_TIME_NS 27000
`define CLK_PERIOD_NS 40
`define EXEC_CYCLES ((`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_OSC_TRIM 3'h4
`define RST_GAIN 3'h2
`define RST_CONTRAST 6'h20
`endif

// ---- rtl/lcd_decoder_pkg.sv ----
// types shared by the instruction decoder files
// assumes no other package
`default_nettype none
package lcd_decoder_pkg;
  typedef enum logic [1:0] {
    RAM_TEXT = 2'b00,
    RAM_GLYPH = 2'b01,
    RAM_ICON = 2'b10
  } ram_sel_t;
  typedef struct packed {
    logic table_select;
    logic two_line;
    logic step_up;
    logic bias_select;
    logic [2:0] osc_trim;
    logic [2:0] follower_gain;
    logic [5:0] contrast_code;
    logic icon_on;
    logic booster_on;
    logic follower_on;
  } settings_t;
  typedef struct packed {
    logic register_select;
    logic read_not_write;
    logic [7:0] db;
  } port_cmd_t;
endpackage
`default_nettype wire

// ---- rtl/lcd_busy_timer.sv ----
// busy timer: holds busy for a fixed execution time after each instruction write or data access
// assumes a single start pulse, one clock
`include "lcd_decoder_consts.svh"
`default_nettype none
module lcd_busy_timer (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // control
  input wire logic start,
  output logic busy
);
  localparam int unsigned CNT = `EXEC_CYCLES;
  logic [9:0] cnt_ff;
  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 10'h000;
    end else if (start) begin
      cnt_ff <= 10'(CNT);
    end else if (cnt_ff != 10'h000) begin
      cnt_ff <= cnt_ff - 10'h001;
    end
  end
  assign busy = (cnt_ff != 10'h000);
endmodule
`default_nettype wire

// ---- rtl/lcd_ram_store.sv ----
// data memories: text, glyph and icon storage
// assumes one access per cycle, address already range checked
`default_nettype none
module lcd_ram_store (
  // clock
  input wire logic clock,
  // access
  input wire logic we,
  input wire logic [1:0] sel,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] text_mem [0:127];
  logic [7:0] glyph_mem [0:63];
  logic [7:0] icon_mem [0:15];
  // ---------------------------------------------------------------
  // writes and combinational reads
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (we && sel == 2'b00) begin
      text_mem[addr] <= wdata;
    end
    if (we && sel == 2'b01) begin
      glyph_mem[addr[5:0]] <= wdata;
    end
    if (we && sel == 2'b10) begin
      icon_mem[addr[3:0]] <= wdata;
    end
  end
  always_comb begin
    case (sel)
      2'b00: rdata = text_mem[addr];
      2'b01: rdata = glyph_mem[addr[5:0]];
      2'b10: rdata = icon_mem[addr[3:0]];
      default: rdata = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// ---- testbench/lcd_host_model.sv ----
// host side model: apb master issuing port commands to the decoder
// assumes one clock and status, port and read data at the header offsets
`include "lcd_decoder_consts.svh"
`default_nettype none
module lcd_host_model (
  // clock
  input wire logic clock,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_rd;
  logic last_err;
  // --------------------------------------------------------------
  // bus transfers
  // --------------------------------------------------------------
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // setup cycle, then access held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle limit here: the bench watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the busy indicator clears
  task automatic wait_idle();
    do begin
      xfer(1'b0, `REG_STATUS, 32'h0000_0000);
    end while (last_rd[7] !== 1'b0);
  endtask
  // byte, select and direction travel in one port word
  task automatic send(input logic rs, input logic rw, input logic [7:0] b);
    wait_idle();
    xfer(1'b1, `REG_PORT, {22'h00_0000, rs, rw, b});
    wait_idle();
  endtask
  // consecutive read: byte lands in the read data register
  task automatic next_read();
    send(1'b1, 1'b1, 8'h00);
    xfer(1'b0, `REG_RDATA, 32'h0000_0000);
  endtask
  // address set ahead of a read, so the first byte is valid
  task automatic fetch(input logic [7:0] set_instr);
    send(1'b0, 1'b0, set_instr);
    next_read();
  endtask
endmodule
`default_nettype wire

// ---- testbench/char_lcd_extended_instr_decoder_bench.sv ----
// bench of the instruction decoder: table of instructions, then hand tests
// assumes decoder, host model and constants header compiled first
`include "lcd_decoder_consts.svh"
`default_nettype none
module char_lcd_extended_instr_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int F_TABLE = 0, F_TWO = 1, F_STEP = 2, F_BIAS = 3, F_TRIM = 4, F_GAIN = 5;
  localparam int F_CONTR = 6, F_ICON = 7, F_BOOST = 8, F_FOLL = 9, F_ACT = 10;
  typedef struct {logic [7:0] instr; int fid; logic [7:0] exp;} row_t;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic opt_a = 1'b0;
  logic opt_b = 1'b0;
  logic osc_pin = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  lcd_decoder_pkg::settings_t settings;
  logic [2:0] osc_trim_active;
  int error_cnt = 0;
  int n_compared = 0;
  row_t rows [13];
  logic [7:0] rst_exp [11] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h04, 8'h02, 8'h20, 8'h00,
                               8'h00, 8'h00, 8'h04};
  // --------------------------------------------------------------
  // clock and instances
  // --------------------------------------------------------------
  // free running clock, 40 ns period
  always #20 clock = ~clock;
  lcd_instr_decoder i_lcd_instr_decoder (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .follower_option_a(opt_a), .follower_option_b(opt_b), .osc_adjust_pin(osc_pin),
    .settings(settings), .osc_trim_active(osc_trim_active)
  );
  lcd_host_model i_lcd_host_model (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // one setting field by index, zero extended
  function automatic logic [7:0] fld(input int id);
    case (id)
      F_TABLE: fld = {7'h00, settings.table_select};
      F_TWO: fld = {7'h00, settings.two_line};
      F_STEP: fld = {7'h00, settings.step_up};
      F_BIAS: fld = {7'h00, settings.bias_select};
      F_TRIM: fld = {5'h00, settings.osc_trim};
      F_GAIN: fld = {5'h00, settings.follower_gain};
      F_CONTR: fld = {2'h0, settings.contrast_code};
      F_ICON: fld = {7'h00, settings.icon_on};
      F_BOOST: fld = {7'h00, settings.booster_on};
      F_FOLL: fld = {7'h00, settings.follower_on};
      default: fld = {5'h00, osc_trim_active};
    endcase
  endfunction
  // compare of any value
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_fld(input int id, input logic [7:0] exp);
    cmp_val({24'h00_0000, fld(id)}, {24'h00_0000, exp});
  endtask
  task automatic chk_ptr(input logic [6:0] exp);
    i_lcd_host_model.xfer(1'b0, `REG_STATUS, 32'h0000_0000);
    cmp_val({25'h0, i_lcd_host_model.last_rd[6:0]}, {25'h0, exp});
  endtask
  task automatic chk_rd(input logic [7:0] exp);
    cmp_val({24'h00_0000, i_lcd_host_model.last_rd[7:0]}, {24'h00_0000, exp});
  endtask
  task automatic chk_err(input logic exp);
    cmp_val({31'h0, i_lcd_host_model.last_err}, {31'h0, exp});
  endtask
  task automatic ins(input logic [7:0] b);
    i_lcd_host_model.send(1'b0, 1'b0, b);
  endtask
  task automatic dat(input logic [7:0] b);
    i_lcd_host_model.send(1'b1, 1'b0, b);
  endtask
  task automatic opts(input logic a, input logic b, input logic p);
    @(posedge clock);
    opt_a <= a;
    opt_b <= b;
    osc_pin <= p;
  endtask
  // verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  // main sequence
  initial begin
    rows[0] = '{8'h21, F_TABLE, 8'h01};
    rows[1] = '{8'h13, F_BIAS, 8'h00};
    rows[2] = '{8'h1D, F_BIAS, 8'h01};
    rows[3] = '{8'h1A, F_ACT, 8'h02};
    rows[4] = '{8'h5B, F_ICON, 8'h01};
    rows[5] = '{8'h56, F_BOOST, 8'h01};
    rows[6] = '{8'h7A, F_CONTR, 8'h2A};
    rows[7] = '{8'h65, F_GAIN, 8'h05};
    rows[8] = '{8'h6D, F_FOLL, 8'h01};
    rows[9] = '{8'h20, F_TABLE, 8'h00};
    rows[10] = '{8'h05, F_STEP, 8'h00};
    rows[11] = '{8'h06, F_STEP, 8'h01};
    rows[12] = '{8'h28, F_TWO, 8'h01};
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    foreach (rst_exp[i]) cmp_fld(i, rst_exp[i]);
    i_lcd_host_model.xfer(1'b0, 12'h020, 32'h0000_0000);
    chk_err(1'b1);
    i_lcd_host_model.xfer(1'b1, `REG_STATUS, 32'h0000_00FF);
    chk_err(1'b1);
    chk_ptr(7'h00);
    foreach (rows[i]) begin
      ins(rows[i].instr);
      cmp_fld(rows[i].fid, rows[i].exp);
    end
    // busy shows at once after an instruction
    i_lcd_host_model.xfer(1'b1, `REG_PORT, 32'h0000_0006);
    i_lcd_host_model.xfer(1'b0, `REG_STATUS, 32'h0000_0000);
    cmp_val({31'h0, i_lcd_host_model.last_rd[7]}, 32'h0000_0001);
    // two-line text: row jump and rejected gap address
    ins(8'hA7);
    chk_ptr(7'h27);
    dat(8'h5A);
    chk_ptr(7'h40);
    dat(8'hC3);
    ins(8'hB0);
    chk_ptr(7'h41);
    i_lcd_host_model.fetch(8'hA7);
    chk_rd(8'h5A);
    i_lcd_host_model.next_read();
    chk_rd(8'hC3);
    // one-line limits and downward wrap
    ins(8'h20);
    ins(8'hCF);
    chk_ptr(7'h4F);
    ins(8'hD0);
    chk_ptr(7'h4F);
    ins(8'h04);
    ins(8'h80);
    dat(8'h77);
    chk_ptr(7'h4F);
    // glyph ram kept apart from text ram
    ins(8'h7F);
    dat(8'h11);
    chk_ptr(7'h3E);
    i_lcd_host_model.fetch(8'h80);
    chk_rd(8'h77);
    i_lcd_host_model.fetch(8'h7F);
    chk_rd(8'h11);
    // icon ram at its top address
    ins(8'h06);
    ins(8'h58);
    cmp_fld(F_ICON, 8'h00);
    dat(8'h22);
    chk_ptr(7'h19);
    ins(8'h21);
    ins(8'h4F);
    chk_ptr(7'h0F);
    dat(8'h1E);
    chk_ptr(7'h00);
    i_lcd_host_model.fetch(8'h4F);
    chk_rd(8'h1E);
    // option straps gate the analog settings
    opts(1'b1, 1'b1, 1'b1);
    ins(8'h10);
    cmp_fld(F_BIAS, 8'h01);
    i_lcd_host_model.xfer(1'b0, `REG_POWER, 32'h0000_0000);
    cmp_val(i_lcd_host_model.last_rd, 32'h0000_0028);
    opts(1'b1, 1'b0, 1'b1);
    ins(8'h60);
    cmp_fld(F_FOLL, 8'h01);
    cmp_fld(F_GAIN, 8'h05);
    ins(8'h58);
    cmp_fld(F_BOOST, 8'h01);
    ins(8'h70);
    cmp_fld(F_CONTR, 8'h2A);
    opts(1'b0, 1'b0, 1'b0);
    ins(8'h13);
    cmp_fld(F_TRIM, 8'h03);
    cmp_fld(F_ACT, 8'h00);
    opts(1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge clock);
    cmp_fld(F_ACT, 8'h03);
    // whole settings word as software sees it
    i_lcd_host_model.xfer(1'b0, `REG_CONFIG, 32'h0000_0000);
    cmp_val(i_lcd_host_model.last_rd, 32'h0005_3B57);
    chk_err(1'b0);
    conclude();
  end
  // watchdog against a hung handshake
  initial begin
    #(90000 * 40);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
